/* fps_flash_protect_status.sv */
// Valid-area protection register, sequencer status register and command gate
`timescale 1ns/100ps
`include "fps_defines.svh"

module fps_flash_protect_status #(
    parameter int INSTANCE = 0 // Sequencer instance index
) (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic reset, // Synchronous, active high
    input wire logic [7:0] regAddr, // Register byte offset
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [3:0] regByteEn, // Byte lanes
    input wire logic [31:0] regWriteData, // Write data
    output logic [31:0] regReadData, // Read data
    output logic regReadValid, // Read data valid
    input wire fps_pkg::fps_events_t flagEvents, // Flag set pulses
    input wire fps_pkg::fps_levels_t flagLevels, // Live status levels
    input wire fps_pkg::fps_cmd_req_t cmdReq, // Incoming command
    input wire logic mapDouble, // Double map mode
    input wire fps_pkg::fps_op_mode_t opMode, // Operating mode
    output logic cmdAccept, // Command taken
    output logic cmdRefused, // Command refused
    output logic commandLock, // Sequencer locked
    output logic [31:0] statusWord // Status register image
);

    logic guardBit;
    logic [31:0] sticky;
    logic [31:0] levels;
    logic [31:0] eventWord;
    logic [31:0] levelWord;
    logic [31:0] flagMask;
    logic [31:0] laneMask;
    logic guardWrite;
    logic keyOk;
    logic setupInit;
    logic protectActive;
    logic protectHit;
    logic normalCmd;
    logic clearStart;

    // Instance 1 lacks the security, boot-protect and configuration ECC monitors
    assign flagMask = (INSTANCE == 0) ? 32'hFFFF_FFFF : ~`FPS_INST0_MASK;

    always_comb begin
        eventWord = 32'h0000_0000;
        eventWord[`FPS_B_SEC_DBL] = flagEvents.security_double_error_flag;
        eventWord[`FPS_B_SEC_FIX] = flagEvents.security_single_fix_flag;
        eventWord[`FPS_B_ILL_CMD] = flagEvents.illegal_command_error;
        eventWord[`FPS_B_EXTRA_SET] = flagEvents.extra_setting_error;
        eventWord[`FPS_B_SEC_ERR] = flagEvents.security_error_flag;
        eventWord[`FPS_B_ONE_TIME] = flagEvents.one_time_error_flag;
        eventWord[`FPS_B_BP_DBL] = flagEvents.bootprotect_double_error_flag;
        eventWord[`FPS_B_BP_FIX] = flagEvents.bootprotect_single_fix_flag;
        eventWord[`FPS_B_ILL_STATE] = flagEvents.illegal_state_error;
        eventWord[`FPS_B_ERASE_ERR] = flagEvents.erase_error_flag;
        eventWord[`FPS_B_PROG_ERR] = flagEvents.program_error_flag;
        eventWord[`FPS_B_HV_ERR] = flagEvents.high_voltage_error_flag;
        eventWord[`FPS_B_CFG_DBL] = flagEvents.config_double_error_flag;
        eventWord[`FPS_B_CFG_FIX] = flagEvents.config_single_fix_flag;
        eventWord[`FPS_B_TBL_DBL] = flagEvents.table_double_error_flag;
        eventWord[`FPS_B_TBL_FIX] = flagEvents.table_single_fix_flag;
    end

    always_comb begin
        levelWord = 32'h0000_0000;
        levelWord[`FPS_B_READY] = flagLevels.sequencer_ready_flag;
        levelWord[`FPS_B_SUSP_RDY] = flagLevels.suspend_ready_flag;
        levelWord[`FPS_B_DATA_FULL] = flagLevels.data_buffer_full_flag;
        levelWord[`FPS_B_ERASE_SUSP] = flagLevels.erase_suspended_flag;
        levelWord[`FPS_B_PROG_SUSP] = flagLevels.program_suspended_flag;
        levelWord[`FPS_B_EXT_FULL] = flagLevels.extra_buffer_full_flag;
    end

    assign statusWord = sticky | levels;

    // Register access decode
    assign setupInit = regWrite && regAddr == `FPS_OFS_SETUP && regByteEn[0]
        && regWriteData[`FPS_SETUP_BIT];
    assign guardWrite = regWrite && regAddr == `FPS_OFS_GUARD && regByteEn[0] && regByteEn[1];
    assign keyOk = regWriteData[`FPS_KEY_MSB:`FPS_KEY_LSB] == `FPS_KEY_ENABLE;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            guardBit <= `FPS_GUARD_RESET;
        end else if (setupInit) begin
            guardBit <= `FPS_GUARD_RESET;
        end else if (guardWrite && keyOk) begin
            guardBit <= regWriteData[`FPS_GUARD_BIT];
        end
    end

    // Command gate
    assign protectActive = guardBit && mapDouble
        && (opMode == fps_pkg::FPS_MODE_NORMAL || opMode == fps_pkg::FPS_MODE_USER_BOOT);
    assign protectHit = protectActive && cmdReq.inValidArea
        && (cmdReq.kind == fps_pkg::FPS_CMD_PROGRAM || cmdReq.kind == fps_pkg::FPS_CMD_BLOCK_ERASE
        || cmdReq.kind == fps_pkg::FPS_CMD_RESUME);
    assign normalCmd = cmdReq.kind != fps_pkg::FPS_CMD_CLEAR_STATUS
        && cmdReq.kind != fps_pkg::FPS_CMD_FORCED_STOP;
    assign commandLock = sticky[`FPS_B_ILL_CMD];
    assign cmdRefused = cmdReq.valid && ((commandLock && normalCmd) || protectHit);
    assign cmdAccept = cmdReq.valid && !cmdRefused;
    assign clearStart = cmdAccept && !normalCmd;

    // A flag raised in the clearing cycle survives the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sticky <= `FPS_STATUS_RESET & `FPS_STICKY_MASK;
        end else begin
            sticky <= ((clearStart ? 32'h0000_0000 : sticky) | eventWord)
                & `FPS_STICKY_MASK & flagMask;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            levels <= `FPS_STATUS_RESET & `FPS_LEVEL_MASK;
        end else begin
            levels <= levelWord & `FPS_LEVEL_MASK;
        end
    end

    // One mask byte per byte lane
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        assign laneMask[lane*8 +: 8] = {8{regByteEn[lane]}};
    end

    // Status is read-only: writes to it fall through and are ignored
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regReadData <= 32'h0000_0000;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (!regRead) begin
                regReadData <= 32'h0000_0000;
            end else if (regAddr == `FPS_OFS_STATUS) begin
                regReadData <= statusWord & laneMask;
            end else if (regAddr == `FPS_OFS_GUARD) begin
                regReadData <= {31'h0000_0000, guardBit} & laneMask;
            end else begin
                regReadData <= 32'h0000_0000;
            end
        end
    end

    sequence s_clear_cmd;
        clearStart && eventWord == 32'h0000_0000;
    endsequence

    sequence s_good_key;
        guardWrite && keyOk && !setupInit;
    endsequence

    a_status_reset: assert property (@(posedge ref_clk) $fell(reset)
        |-> statusWord == `FPS_STATUS_RESET)
        else $error("status not at reset value after reset");

    a_setup_clears: assert property (@(posedge ref_clk) disable iff (reset) setupInit
        |=> guardBit == `FPS_GUARD_RESET)
        else $error("setup init did not restore guard");

    a_key_reject: assert property (@(posedge ref_clk) disable iff (reset)
        guardWrite && !keyOk && !setupInit |=> $stable(guardBit))
        else $error("guard changed without key");

    a_key_accept: assert property (@(posedge ref_clk) disable iff (reset)
        s_good_key |=> guardBit == $past(regWriteData[`FPS_GUARD_BIT]))
        else $error("guard not written with key");

    a_guard_resv_zero: assert property (@(posedge ref_clk) disable iff (reset)
        regRead && regAddr == `FPS_OFS_GUARD
        |=> regReadValid && regReadData[`FPS_RESV_MSB:`FPS_RESV_LSB] == 7'h00)
        else $error("reserved guard bits not zero");

    a_protect_refuse: assert property (@(posedge ref_clk) disable iff (reset)
        cmdReq.valid && guardBit && mapDouble && opMode != fps_pkg::FPS_MODE_SERIAL
        && cmdReq.inValidArea && cmdReq.kind == fps_pkg::FPS_CMD_PROGRAM |-> cmdRefused)
        else $error("protected program not refused");

    a_unprotected_open: assert property (@(posedge ref_clk) disable iff (reset)
        cmdReq.valid && !commandLock && (!mapDouble || opMode == fps_pkg::FPS_MODE_SERIAL
        || !guardBit) |-> cmdAccept)
        else $error("command refused with protection off");

    a_status_read: assert property (@(posedge ref_clk) disable iff (reset)
        regRead && regAddr == `FPS_OFS_STATUS && regByteEn == 4'hF
        |=> regReadValid && regReadData == $past(statusWord))
        else $error("status read data wrong");

    a_inst1_zero: assert property (@(posedge ref_clk) disable iff (reset)
        INSTANCE != 0 |-> (statusWord & `FPS_INST0_MASK) == 32'h0000_0000)
        else $error("instance-0-only flag visible");

    // Whole lock span is watched, not only its first cycle
    a_lock_refuse: assert property (@(posedge ref_clk) disable iff (reset)
        sticky[`FPS_B_ILL_CMD] && cmdReq.valid && normalCmd |-> cmdRefused)
        else $error("normal command taken in lock");

    a_clear_flags: assert property (@(posedge ref_clk) disable iff (reset)
        s_clear_cmd |=> sticky == 32'h0000_0000
        ##1 (!commandLock || $past(eventWord) != 32'h0000_0000))
        else $error("flags not cleared by clear command");

    a_read_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !regRead |=> !regReadValid && regReadData == 32'h0000_0000)
        else $error("read port not idle without a read");

    // Set must survive a clear in the same cycle
    a_event_sets: assert property (@(posedge ref_clk) disable iff (reset)
        eventWord != 32'h0000_0000
        |=> (sticky & $past(eventWord) & flagMask) == ($past(eventWord) & flagMask))
        else $error("flag event lost");

    a_lane_guard: assert property (@(posedge ref_clk) disable iff (reset)
        regWrite && regAddr == `FPS_OFS_GUARD && !(regByteEn[0] && regByteEn[1]) && !setupInit
        |=> $stable(guardBit))
        else $error("guard changed by partial-lane write");

    a_clear_in_lock: assert property (@(posedge ref_clk) disable iff (reset)
        cmdReq.valid && !normalCmd |-> cmdAccept)
        else $error("clear or forced stop refused");

    a_ready_follow: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> statusWord[`FPS_B_READY] == $past(flagLevels.sequencer_ready_flag))
        else $error("ready flag not at its bit position");

endmodule : fps_flash_protect_status

/* fps_defines.svh */
// Offsets, field positions, reset values and key code of the protect/status block
// Operation
// - Writing 1 to the setup-initialise bit returns the protection register to its initial value.
// - The protection bit changes only when the write carries the enabling code in bits 15 to 8.
// - Bits 7 to 1 of the protection register read as zero and software writes them as zero.
// - With the bit set, double map and normal or user-boot mode, program, erase and resume to the valid area are refused.
// - Single map mode or serial programming mode never protects the valid area.
// - The status register sits at offset 0080 hex, is read in 8, 16 or 32 bits and is read-only.
// - After reset the status register reads 0000 8000 hex with only the ready flag set.
// - Security, boot-protect and configuration ECC flags exist only in instance 0 and read zero elsewhere.
// - A set illegal-command error puts the sequencer in command lock, refusing normal commands.
// - Latched error and ECC flags clear when a status-clear or forced-stop command starts.
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_OFS_STATUS 8'h80
`define FPS_OFS_GUARD 8'h84
`define FPS_OFS_SETUP 8'h88

`define FPS_SETUP_BIT 0
`define FPS_KEY_MSB 15
`define FPS_KEY_LSB 8
`define FPS_KEY_ENABLE 8'hA5
`define FPS_GUARD_BIT 0
`define FPS_GUARD_RESET 1'b0
`define FPS_RESV_MSB 7
`define FPS_RESV_LSB 1

`define FPS_STATUS_RESET 32'h0000_8000
`define FPS_STICKY_MASK 32'h03F3_707C
`define FPS_LEVEL_MASK 32'h0004_8F00
`define FPS_INST0_MASK 32'h0303_0030

`define FPS_B_SEC_DBL 25
`define FPS_B_SEC_FIX 24
`define FPS_B_ILL_CMD 23
`define FPS_B_EXTRA_SET 22
`define FPS_B_SEC_ERR 21
`define FPS_B_ONE_TIME 20
`define FPS_B_EXT_FULL 18
`define FPS_B_BP_DBL 17
`define FPS_B_BP_FIX 16
`define FPS_B_READY 15
`define FPS_B_ILL_STATE 14
`define FPS_B_ERASE_ERR 13
`define FPS_B_PROG_ERR 12
`define FPS_B_SUSP_RDY 11
`define FPS_B_DATA_FULL 10
`define FPS_B_ERASE_SUSP 9
`define FPS_B_PROG_SUSP 8
`define FPS_B_HV_ERR 6
`define FPS_B_CFG_DBL 5
`define FPS_B_CFG_FIX 4
`define FPS_B_TBL_DBL 3
`define FPS_B_TBL_FIX 2

`endif

/* fps_pkg.sv */
// Types shared by the protect/status block and its users
package fps_pkg;

    typedef enum logic [2:0] {
        FPS_CMD_PROGRAM,
        FPS_CMD_BLOCK_ERASE,
        FPS_CMD_RESUME,
        FPS_CMD_CLEAR_STATUS,
        FPS_CMD_FORCED_STOP,
        FPS_CMD_OTHER
    } fps_cmd_t;

    typedef enum logic [1:0] {
        FPS_MODE_NORMAL,
        FPS_MODE_USER_BOOT,
        FPS_MODE_SERIAL
    } fps_op_mode_t;

    typedef struct packed {
        logic security_double_error_flag;
        logic security_single_fix_flag;
        logic illegal_command_error;
        logic extra_setting_error;
        logic security_error_flag;
        logic one_time_error_flag;
        logic bootprotect_double_error_flag;
        logic bootprotect_single_fix_flag;
        logic illegal_state_error;
        logic erase_error_flag;
        logic program_error_flag;
        logic high_voltage_error_flag;
        logic config_double_error_flag;
        logic config_single_fix_flag;
        logic table_double_error_flag;
        logic table_single_fix_flag;
    } fps_events_t;

    typedef struct packed {
        logic sequencer_ready_flag;
        logic suspend_ready_flag;
        logic data_buffer_full_flag;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic extra_buffer_full_flag;
    } fps_levels_t;

    typedef struct packed {
        logic valid;
        fps_cmd_t kind;
        logic inValidArea;
    } fps_cmd_req_t;

endpackage : fps_pkg

/* flash_protect_status_bench.sv */
// Self-checking bench for the protect/status block against a behavioural model
`timescale 1ns/100ps
`include "fps_defines.svh"

module flash_protect_status_bench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [3:0] regByteEn = 4'h0;
    logic [31:0] regWriteData = 32'h0;
    fps_pkg::fps_events_t flagEvents = '0;
    fps_pkg::fps_levels_t flagLevels = 6'h20;
    fps_pkg::fps_cmd_req_t cmdReq = '0;
    logic mapDouble = 1'b0;
    fps_pkg::fps_op_mode_t opMode = fps_pkg::FPS_MODE_NORMAL;
    logic [31:0] regReadData, regReadData1, statusWord, statusWord1, laneMask;
    logic regReadValid, cmdAccept, cmdRefused, commandLock;
    logic [31:0] mSticky, mLevel, mRead;
    logic mGuard, mValid, isClr, isProt, mRefuse;
    int n_errors = 0;
    int total_checks = 0;

    fps_flash_protect_status #(.INSTANCE(0)) dut (.ref_clk(ref_clk), .reset(reset),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regByteEn(regByteEn),
        .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
        .flagEvents(flagEvents), .flagLevels(flagLevels), .cmdReq(cmdReq), .mapDouble(mapDouble),
        .opMode(opMode), .cmdAccept(cmdAccept), .cmdRefused(cmdRefused),
        .commandLock(commandLock), .statusWord(statusWord));
    // Second instance sees identical traffic; only its status image differs
    fps_flash_protect_status #(.INSTANCE(1)) dut1 (.ref_clk(ref_clk), .reset(reset),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regByteEn(regByteEn),
        .regWriteData(regWriteData), .regReadData(regReadData1), .regReadValid(),
        .flagEvents(flagEvents), .flagLevels(flagLevels), .cmdReq(cmdReq), .mapDouble(mapDouble),
        .opMode(opMode), .cmdAccept(), .cmdRefused(), .commandLock(),
        .statusWord(statusWord1));

    function automatic logic [31:0] evWord(fps_pkg::fps_events_t e);
        evWord = {6'h0, e[15:10], 2'h0, e[9:8], 1'b0, e[7:5], 5'h0, e[4:0], 2'h0};
    endfunction : evWord

    function automatic logic [31:0] lvWord(fps_pkg::fps_levels_t l);
        lvWord = {13'h0, l[0], 2'h0, l[5], 3'h0, l[4:1], 8'h0};
    endfunction : lvWord

    assign laneMask = {{8{regByteEn[3]}}, {8{regByteEn[2]}}, {8{regByteEn[1]}}, {8{regByteEn[0]}}};
    assign isClr = cmdReq.valid && cmdReq.kind inside {fps_pkg::FPS_CMD_CLEAR_STATUS,
        fps_pkg::FPS_CMD_FORCED_STOP};
    assign isProt = mGuard && mapDouble && opMode != fps_pkg::FPS_MODE_SERIAL
        && cmdReq.inValidArea && cmdReq.kind inside {fps_pkg::FPS_CMD_PROGRAM,
        fps_pkg::FPS_CMD_BLOCK_ERASE, fps_pkg::FPS_CMD_RESUME};
    assign mRefuse = cmdReq.valid && (isProt || (mSticky[23] && !isClr));

    always @(posedge ref_clk) begin
        if (reset) begin
            mSticky <= 32'h0;
            mLevel <= `FPS_STATUS_RESET;
            mGuard <= `FPS_GUARD_RESET;
            mValid <= 1'b0;
            mRead <= 32'h0;
        end else begin
            // Set wins over clear in the same cycle
            mSticky <= (isClr ? 32'h0 : mSticky) | evWord(flagEvents);
            mLevel <= lvWord(flagLevels);
            if (regWrite && regAddr == 8'h84 && regByteEn[1:0] == 2'h3
                && regWriteData[15:8] == 8'hA5) begin
                mGuard <= regWriteData[0];
            end
            if (regWrite && regAddr == 8'h88 && regByteEn[0] && regWriteData[0]) begin
                mGuard <= 1'b0;
            end
            mValid <= regRead;
            mRead <= !regRead ? 32'h0 : regAddr == 8'h80 ? (mSticky | mLevel) & laneMask
                : regAddr == 8'h84 ? {31'h0, mGuard} & laneMask : 32'h0;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    always @(negedge ref_clk) begin
        #1;
        if (!reset) begin
            chk(statusWord, mSticky | mLevel);
            chk(statusWord1, (mSticky | mLevel) & ~`FPS_INST0_MASK);
            chk(32'({regReadValid, commandLock}), 32'({mValid, mSticky[23]}));
            chk(32'({cmdRefused, cmdAccept}), 32'({mRefuse, cmdReq.valid && !mRefuse}));
            chk(regReadData, mRead);
            chk(regReadData1, mRead & ~`FPS_INST0_MASK);
        end
    end

    task automatic drive();
        int op;
        op = $urandom % 4;
        regWrite = (op == 0);
        regRead = (op == 1);
        regAddr = 8'h80 + 8'(4 * ($urandom % 4));
        // The setup offset has no read image to model
        if (regRead && regAddr == 8'h88) regAddr = 8'h84;
        regByteEn = ($urandom % 2) ? 4'hF : 4'($urandom);
        regWriteData = {16'($urandom), ($urandom % 2) ? 8'hA5 : 8'($urandom), 7'h0,
            1'($urandom)};
        flagEvents = ($urandom % 8 == 0) ? 16'($urandom) : 16'h0;
        flagLevels = 6'($urandom);
        cmdReq = fps_pkg::fps_cmd_req_t'({1'($urandom), 3'($urandom % 6), 1'($urandom)});
        mapDouble = ($urandom % 4) != 0;
        opMode = fps_pkg::fps_op_mode_t'($urandom % 3);
    endtask : drive

    task automatic run_test(input string name, input int cycles);
        repeat (cycles) begin
            @(negedge ref_clk);
            drive();
        end
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask : run_test

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        #(20000 * 4);
        n_errors++;
        close_out();
    end

    initial begin
        void'($urandom(1));
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        #1 chk(statusWord, 32'h0000_8000);
        run_test("random_traffic", 2000);
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        #1 chk(statusWord, 32'h0000_8000);
        run_test("after_midrun_reset", 1500);
        close_out();
    end
endmodule : flash_protect_status_bench
